/* logic/pcs_pkg.sv */
// Package for the program counter and return stack block.
package pcs_pkg;
	localparam int PC_W     = 13;
	localparam int TGT_W    = 11;
	localparam int STK_D    = 8;
	localparam int SP_W     = 3;
	// Register byte offsets on the bus.
	localparam logic [11:0] OFS_LOW   = 12'h000;
	localparam logic [11:0] OFS_LATCH = 12'h004;
	localparam logic [11:0] OFS_CMD   = 12'h008;
	localparam logic [11:0] OFS_PC    = 12'h00C;
	localparam logic [11:0] OFS_TGT   = 12'h010;
	// Command codes written to the command register.
	localparam logic [2:0] CMD_STEP  = 3'h1;
	localparam logic [2:0] CMD_JUMP  = 3'h2;
	localparam logic [2:0] CMD_CALL  = 3'h3;
	localparam logic [2:0] CMD_RET   = 3'h4;
	localparam logic [2:0] CMD_RETLIT = 3'h5;
	localparam logic [2:0] CMD_RETINT = 3'h6;
	localparam logic [2:0] CMD_IRQ   = 3'h7;
	localparam logic [12:0] PC_RST   = 13'h0000;
	localparam logic [12:0] VEC_IRQ  = 13'h0004;
	localparam logic [7:0]  LATCH_RST = 8'h00;
	localparam logic [12:0] MEM_512  = 13'h01FF;
	localparam logic [12:0] MEM_1K   = 13'h03FF;
	localparam logic [1:0] RESP_OK   = 2'h0;
	localparam logic [1:0] RESP_SLV  = 2'h2;
	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} pcs_rd_s;
endpackage

/* logic/pcs_core.sv */
// Program counter, high latch and eight-deep return stack behind AXI4-Lite.
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module pcs_core #(
	parameter bit BIG_MEM = 1'b1
) (
	input  wire logic        aclk,    // Core clock.
	input  wire logic        aresetn, // Synchronous reset, active low.
	input  wire logic [11:0] awaddr,  // Write address.
	input  wire logic        awvalid, // Write address valid.
	output logic             awready, // Write address ready.
	input  wire logic [31:0] wdata,   // Write data.
	input  wire logic [3:0]  wstrb,   // Write strobes.
	input  wire logic        wvalid,  // Write data valid.
	output logic             wready,  // Write data ready.
	output logic [1:0]       bresp,   // Write response.
	output logic             bvalid,  // Write response valid.
	input  wire logic        bready,  // Write response ready.
	input  wire logic [11:0] araddr,  // Read address.
	input  wire logic        arvalid, // Read address valid.
	output logic             arready, // Read address ready.
	output logic [31:0]      rdata,   // Read data.
	output logic [1:0]       rresp,   // Read response.
	output logic             rvalid,  // Read data valid.
	input  wire logic        rready,  // Read data ready.
	output logic [12:0]      fetch_addr // Current program counter.
);
	import pcs_pkg::*;

	logic [12:0] program_counter;
	logic [7:0]  counter_high_latch;
	logic [12:0] stack_mem [STK_D];
	logic [SP_W-1:0] sp;
	logic [10:0] target;
	logic        aw_held;
	logic        w_held;
	logic [11:0] aw_q;
	logic [31:0] w_q;
	logic [3:0]  s_q;

	function automatic logic [12:0] fold(input logic [12:0] a);
		// The unused upper part of page zero aliases back into the array.
		fold = a & (BIG_MEM ? MEM_1K : MEM_512);
	endfunction

	wire         aw_now   = awvalid && awready;
	wire         w_now    = wvalid && wready;
	wire         have_aw  = aw_held || aw_now;
	wire         have_w   = w_held || w_now;
	wire [11:0]  waddr    = aw_held ? aw_q : awaddr;
	wire [31:0]  wd       = w_held ? w_q : wdata;
	wire [3:0]   ws       = w_held ? s_q : wstrb;
	wire         do_wr    = have_aw && have_w && !bvalid;
	wire         wr_low   = do_wr && waddr == OFS_LOW && ws[0];
	wire         wr_latch = do_wr && waddr == OFS_LATCH && ws[0];
	wire         wr_cmd   = do_wr && waddr == OFS_CMD && ws[0];
	wire         wr_tgt   = do_wr && waddr == OFS_TGT && (ws[0] || ws[1]);
	wire         wr_known = waddr == OFS_LOW || waddr == OFS_LATCH || waddr == OFS_CMD
		|| waddr == OFS_TGT || waddr == OFS_PC;
	wire [2:0]   cmd      = wd[2:0];
	wire         is_push  = wr_cmd && (cmd == CMD_CALL || cmd == CMD_IRQ);
	wire         is_pop   = wr_cmd && (cmd == CMD_RET || cmd == CMD_RETLIT
		|| cmd == CMD_RETINT);
	wire [SP_W-1:0] sp_dec = sp - 3'h1;
	// The entry a pop returns, named so the checks below can compare against it.
	wire [12:0]  pop_val   = stack_mem[sp_dec];
	// Page bits four and three of the latch are dropped: only page zero exists.
	wire [12:0]  branch_pc = {2'b00, target};
	wire [12:0]  low_pc    = {counter_high_latch[4:0], wd[7:0]};
	wire [12:0]  step_pc   = program_counter + 13'h0001;

	logic [12:0] next_pc;
	always_comb begin
		next_pc = program_counter;
		if (wr_low) begin
			next_pc = fold(low_pc);
		end else if (wr_cmd) begin
			case (cmd)
				CMD_STEP:   next_pc = fold(step_pc);
				CMD_JUMP,
				CMD_CALL:   next_pc = fold(branch_pc);
				CMD_RET,
				CMD_RETLIT,
				CMD_RETINT: next_pc = pop_val;
				CMD_IRQ:    next_pc = VEC_IRQ;
				default:    next_pc = program_counter;
			endcase
		end
	end

	// Bus handshake: each channel is taken once, then held until the response.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_q    <= 12'h000;
			w_q     <= 32'h0000_0000;
			s_q     <= 4'h0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OK;
		end else begin
			awready <= !have_aw && !bvalid && !awready;
			wready  <= !have_w && !bvalid && !wready;
			if (aw_now) begin
				aw_held <= 1'b1;
				aw_q    <= awaddr;
			end
			if (w_now) begin
				w_held <= 1'b1;
				w_q    <= wdata;
				s_q    <= wstrb;
			end
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_known ? RESP_OK : RESP_SLV;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Counter, latch and stack. The stack wraps silently: no overflow flag exists.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			program_counter    <= PC_RST;
			counter_high_latch <= LATCH_RST;
			target             <= 11'h000;
			sp                 <= 3'h0;
			fetch_addr         <= PC_RST;
		end else begin
			program_counter <= next_pc;
			fetch_addr      <= next_pc;
			// Only the latch register itself changes the latch, never the stack.
			if (wr_latch) begin
				counter_high_latch <= {3'b000, wd[4:0]};
			end
			if (wr_tgt) begin
				target <= wd[10:0];
			end
			if (is_push) begin
				stack_mem[sp] <= program_counter;
				sp            <= sp + 3'h1;
			end else if (is_pop) begin
				sp <= sp_dec;
			end
		end
	end

	// Reads: the low byte and the latch are visible, the stack pointer is not.
	wire         rd_known = araddr == OFS_LOW || araddr == OFS_LATCH || araddr == OFS_CMD
		|| araddr == OFS_TGT || araddr == OFS_PC;
	pcs_rd_s     rd_sel;
	always_comb begin
		rd_sel.valid = rd_known;
		case (araddr)
			OFS_LOW:   rd_sel.data = {24'h000000, program_counter[7:0]};
			OFS_LATCH: rd_sel.data = {24'h000000, counter_high_latch};
			OFS_TGT:   rd_sel.data = {21'h00000, target};
			OFS_PC:    rd_sel.data = {19'h0000, program_counter};
			default:   rd_sel.data = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OK;
		end else begin
			arready <= !rvalid && !arready && arvalid;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata  <= rd_sel.data;
				rresp  <= rd_sel.valid ? RESP_OK : RESP_SLV;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	property p_irq_vector;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && cmd == CMD_IRQ) |=> program_counter == VEC_IRQ;
	endproperty
	a_irq_vector: assert property (p_irq_vector) else $error("Vector not loaded.");

	property p_push_saves;
		@(posedge aclk) disable iff (!aresetn)
		is_push |=> stack_mem[$past(sp)] == $past(program_counter);
	endproperty
	a_push_saves: assert property (p_push_saves) else $error("Push lost value.");

	property p_pop_restores;
		@(posedge aclk) disable iff (!aresetn)
		is_pop |=> program_counter == $past(pop_val);
	endproperty
	a_pop_restores: assert property (p_pop_restores) else $error("Pop mismatch.");

	property p_latch_kept;
		@(posedge aclk) disable iff (!aresetn)
		(is_push || is_pop) |=> $stable(counter_high_latch);
	endproperty
	a_latch_kept: assert property (p_latch_kept) else $error("Latch changed.");

	property p_low_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_low |=> program_counter[7:0] == $past(wd[7:0])
			&& program_counter[12:8] == ($past(counter_high_latch[4:0]) & 5'h03);
	endproperty
	a_low_write: assert property (p_low_write) else $error("Low write wrong.");

	property p_jump_page0;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && cmd == CMD_JUMP) |=> program_counter[12:10] == 3'b000;
	endproperty
	a_jump_page0: assert property (p_jump_page0) else $error("Left page zero.");

	property p_step;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && cmd == CMD_STEP && program_counter < MEM_512)
			|=> program_counter == $past(program_counter) + 13'h0001;
	endproperty
	a_step: assert property (p_step) else $error("Step wrong.");

	property p_wrap;
		@(posedge aclk) disable iff (!aresetn)
		is_push |=> sp == $past(sp) + 3'h1;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Pointer wrong.");

	property p_idle;
		@(posedge aclk) disable iff (!aresetn)
		!do_wr |=> $stable(program_counter);
	endproperty
	a_idle: assert property (p_idle) else $error("Counter drifted.");

	// The fetch address is a registered copy so it can leave the block without logic after it.
	property p_fetch_mirror;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |-> fetch_addr == program_counter;
	endproperty
	a_fetch_mirror: assert property (p_fetch_mirror) else $error("Fetch differs.");

	property p_pop_ptr;
		@(posedge aclk) disable iff (!aresetn)
		is_pop |=> sp == $past(sp_dec);
	endproperty
	a_pop_ptr: assert property (p_pop_ptr) else $error("Pop pointer wrong.");

	property p_sp_hold;
		@(posedge aclk) disable iff (!aresetn)
		!(is_push || is_pop) |=> $stable(sp);
	endproperty
	a_sp_hold: assert property (p_sp_hold) else $error("Pointer moved.");

	property p_call_target;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && cmd == CMD_CALL) |=> program_counter[8:0] == $past(target[8:0])
			&& program_counter[12:10] == 3'b000;
	endproperty
	a_call_target: assert property (p_call_target) else $error("Call target wrong.");

	property p_target_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_tgt |=> target == $past(wd[10:0]);
	endproperty
	a_target_write: assert property (p_target_write) else $error("Target not kept.");

	property p_latch_write;
		@(posedge aclk) disable iff (!aresetn)
		wr_latch |=> counter_high_latch == {3'b000, $past(wd[4:0])};
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("Latch not kept.");

	property p_read_low;
		@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready && araddr == OFS_LOW) |=> rdata == {24'h000000, $past(program_counter[7:0])};
	endproperty
	a_read_low: assert property (p_read_low) else $error("Low byte read wrong.");

	property p_rd_unmapped;
		@(posedge aclk) disable iff (!aresetn)
		(arvalid && arready && !rd_known) |=> rresp == RESP_SLV && rdata == 32'h0000_0000;
	endproperty
	a_rd_unmapped: assert property (p_rd_unmapped) else $error("Unmapped read answered.");

	property p_unmapped_write;
		@(posedge aclk) disable iff (!aresetn)
		(do_wr && !wr_known) |=> bresp == RESP_SLV && $stable(program_counter);
	endproperty
	a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write acted.");

	// A response must not change under the master while it waits to take it.
	property p_bvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		(bvalid && !bready) |=> bvalid && $stable(bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold) else $error("Write response dropped.");

	property p_rvalid_hold;
		@(posedge aclk) disable iff (!aresetn)
		(rvalid && !rready) |=> rvalid && $stable(rdata) && $stable(rresp);
	endproperty
	a_rvalid_hold: assert property (p_rvalid_hold) else $error("Read response dropped.");

	property p_no_ready_busy;
		@(posedge aclk) disable iff (!aresetn)
		bvalid |-> !awready && !wready;
	endproperty
	a_no_ready_busy: assert property (p_no_ready_busy) else $error("Ready while busy.");

	property p_irq_push;
		@(posedge aclk) disable iff (!aresetn)
		(wr_cmd && cmd == CMD_IRQ) |=> stack_mem[$past(sp)] == $past(program_counter);
	endproperty
	a_irq_push: assert property (p_irq_push) else $error("Interrupt push lost.");

	c_call: cover property (@(posedge aclk) disable iff (!aresetn) wr_cmd && cmd == CMD_CALL);
	c_wrap: cover property (@(posedge aclk) disable iff (!aresetn) is_push && sp == 3'h7);
	c_ret: cover property (@(posedge aclk) disable iff (!aresetn) is_pop);
	c_irq: cover property (@(posedge aclk) disable iff (!aresetn) wr_cmd && cmd == CMD_IRQ);
	c_low: cover property (@(posedge aclk) disable iff (!aresetn) wr_low);
endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the program counter and return stack block.
`timescale 1ns/1ps
module tb_top;
	import pcs_pkg::*;
	typedef struct packed {
		logic [11:0] a;
		logic [31:0] d;
		logic [12:0] pc;
	} pcs_row_s;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd_val;
	logic [12:0] fetch_addr;
	int          err_count = 0;
	int          samples_checked = 0;
	// Each row: the write, then the counter value it must leave behind.
	pcs_row_s    rows [0:11] = '{
		'{OFS_LATCH, 32'h1F, 13'h0000}, '{OFS_LOW, 32'h34, 13'h0334},
		'{OFS_CMD, 32'(CMD_STEP), 13'h0335}, '{OFS_TGT, 32'h7FF, 13'h0335},
		'{OFS_CMD, 32'(CMD_JUMP), 13'h03FF}, '{OFS_CMD, 32'(CMD_STEP), 13'h0000},
		'{OFS_TGT, 32'h123, 13'h0000}, '{OFS_CMD, 32'(CMD_CALL), 13'h0123},
		'{OFS_CMD, 32'(CMD_IRQ), 13'h0004}, '{OFS_CMD, 32'(CMD_RETINT), 13'h0123},
		'{OFS_CMD, 32'(CMD_RETLIT), 13'h0000}, '{OFS_PC, 32'h1555, 13'h0000}};
	always #20 aclk = ~aclk;
	pcs_core #(.BIG_MEM(1'b1)) u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .fetch_addr(fetch_addr));
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Address and data are released separately, each at its own handshake edge.
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_done, w_done, b_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b_done) begin
			@(posedge aclk);
			if (!aw_done && awready === 1'b1) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
			if (bvalid === 1'b1) begin
				b_done = 1'b1;
				resp = bresp;
				bready <= 1'b0;
			end
		end
		@(posedge aclk);
	endtask
	task rd(input logic [11:0] a);
		logic r_done;
		r_done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r_done) begin
			@(posedge aclk);
			if (arvalid === 1'b1 && arready === 1'b1)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				r_done = 1'b1;
				rd_val = rdata;
				resp = rresp;
				rready <= 1'b0;
			end
		end
		@(posedge aclk);
	endtask
	task end_of_test;
		$display("checked %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task reset_check;
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFS_LATCH);
		chk("latch after reset", rd_val, 32'h0);
		rd(OFS_PC);
		chk("counter after reset", rd_val, 32'h0);
		chk("fetch after reset", 32'(fetch_addr), 32'h0);
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		err_count++;
		end_of_test;
	end
	initial begin
		reset_check;
		for (int i = 0; i < 12; i++) begin
			wr(rows[i].a, rows[i].d);
			chk("write resp", 32'(resp), 32'(RESP_OK));
			rd(OFS_PC);
			chk("counter", rd_val, 32'(rows[i].pc));
			chk("fetch", 32'(fetch_addr), 32'(rows[i].pc));
			rd(OFS_LOW);
			chk("low byte", rd_val, {24'h0, rows[i].pc[7:0]});
		end
		rd(OFS_LATCH);
		chk("latch kept", rd_val, 32'h1F);
		rd(OFS_CMD);
		chk("command reads zero", rd_val, 32'h0);
		// Nine pushes of distinct high addresses, then nine pops.
		for (int i = 0; i < 9; i++) begin
			wr(OFS_TGT, 32'h3F0 + i);
			wr(OFS_CMD, 32'(CMD_JUMP));
			wr(OFS_CMD, 32'(CMD_IRQ));
		end
		for (int i = 0; i < 9; i++) begin
			wr(OFS_CMD, 32'(CMD_RET));
			chk("pop", 32'(fetch_addr), (i == 0 || i == 8) ? 32'h3F8 : 32'h3F8 - i);
		end
		rd(OFS_LATCH);
		chk("latch after stack", rd_val, 32'h1F);
		wr(12'h020, 32'h5);
		chk("unmapped write resp", 32'(resp), 32'(RESP_SLV));
		chk("unmapped write no effect", 32'(fetch_addr), 32'h3F8);
		rd(12'h020);
		chk("unmapped read resp", 32'(resp), 32'(RESP_SLV));
		chk("unmapped read data", rd_val, 32'h0);
		reset_check;
		end_of_test;
	end
endmodule
